// >>> shared/cpu_state_pkg.sv
// package: constants and carriers for the flags and segment state block
package cpu_state_pkg;
    // ********************
    // flags word bit positions
    // ********************
    localparam int CY_BIT   = 0;
    localparam int PY_BIT   = 2;
    localparam int AC_BIT   = 4;
    localparam int ZR_BIT   = 6;
    localparam int SG_BIT   = 7;
    localparam int ST_BIT   = 8;
    localparam int IF_BIT   = 9;
    localparam int DR_BIT   = 10;
    localparam int OV_BIT   = 11;
    localparam int IOPV_LO  = 12;
    localparam int NS_BIT   = 14;
    localparam int RS_BIT   = 16;
    localparam int VT_BIT   = 17;
    localparam logic [31:0] FLAGS_DEFINED = 32'h0003_7fd5;
    localparam logic [31:0] FLAGS_LOW16   = 32'h0000_ffff;
    localparam logic [31:0] FLAGS_IOPV    = 32'h0000_3000;
    localparam logic [31:0] FLAGS_RESET   = 32'h0000_0000;
    // ********************
    // machine control word
    // ********************
    localparam int PM_BIT = 0;
    localparam int PU_BIT = 31;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // ********************
    // segment state
    // ********************
    localparam int NUM_SEGS       = 6;
    localparam int REAL_SHIFT     = 4;
    localparam int ATTR_WRITE_BIT = 1;
    localparam int ATTR_PRES_BIT  = 7;
    localparam logic [7:0] ATTR_RESET = 8'h93;
    localparam logic [31:0] LIMIT_RESET = 32'h0000_ffff;
    // ********************
    // enumerations and carriers
    // ********************
    typedef enum logic [1:0] {SIZE8, SIZE16, SIZE32} size_e;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_RETIRE, CMD_PUSH, CMD_POPF16, CMD_POPF32,
        CMD_INTERRUPT_RETURN, CMD_TASK_SWITCH, CMD_INT_ENTRY, CMD_LOAD_CONTROL,
        CMD_LOAD_STATUS
    } cmd_e;
    typedef struct packed {
        cmd_e        op;
        logic        fault;
        logic        nest;
        logic [31:0] image;
    } cmd_s;
    typedef struct packed {
        logic        valid;
        logic        sub;
        size_e       size;
        logic [5:0]  update;
        logic [31:0] a;
        logic [31:0] b;
    } alu_req_s;
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic [7:0]  attr;
    } seg_desc_s;
    typedef struct packed {
        logic        valid;
        logic [2:0]  index;
        logic [15:0] selector;
        seg_desc_s   desc;
    } seg_load_s;
endpackage

// >>> hw/cpu_flags_and_segment_state.sv
// flags word, machine control word and hidden segment state of the processor
// Operation
// - legacy virtual flag set only in protected mode, by return at level 0 or task switch
// - push of flags word always stores zero in the legacy virtual bit
// - interrupt or task save image carries one in virtual bit for virtual tasks
// - resume flag set suppresses debug faults on the next instruction
// - resume flag clears on clean completion; 32-bit pops, returns and task switches load it from image, 16-bit pops keep it
// - nested flag set by task transfers, tested by return, loaded by pops
// - protected mode I/O allowed directly only when privilege <= I/O privilege field
// - pops change I/O privilege field only at level 0; task switches always load it
// - pops change interrupt enable only when privilege <= I/O privilege field
// - maskable interrupt recognised only while interrupt enable is one
// - overflow set when carry into sign bit differs from carry out
// - string indexes increment when direction clear, decrement when set
// - single-step flag raises trap after next instruction
// - sign flag equals top result bit for the operand size
// - zero flag set when whole result is zero
// - auxiliary carry from carry out of or borrow into bit 3
// - parity flag set for even ones in low eight result bits
// - carry flag from carry out of or borrow into top bit
// - real mode selector load sets base to selector shifted left four
// - protected mode load takes base, limit, attributes from descriptor; references check them
// - status word load writes only low 16 control bits; store reads them
// - paging unit enabled while paging enable bit is one
// - protected mode bit cleared only by full control word load
module cpu_flags_and_segment_state
    import cpu_state_pkg::*;
(
    input  wire logic        clk,              // processor clock
    input  wire logic        reset,            // synchronous, active high
    input  wire logic        maskable_interrupt_input, // external request pin
    input  wire logic [1:0]  current_privilege_level,  // running privilege
    input  wire cmd_s        cmd,              // instruction completion command
    input  wire alu_req_s    alu_req,          // arithmetic flag request
    input  wire seg_load_s   seg_load,         // selector load with descriptor
    input  wire logic        ref_valid,        // memory reference request
    input  wire logic [2:0]  ref_seg,          // segment used by reference
    input  wire logic [31:0] ref_offset,       // offset in segment
    input  wire logic        ref_write,        // reference is a write
    input  wire logic        str_valid,        // string index step request
    input  wire size_e       str_size,         // string element size
    input  wire logic [31:0] str_src,          // current source index
    input  wire logic [31:0] str_dst,          // current destination index
    output logic [31:0]      processor_flags_word, // live flags word
    output logic [31:0]      machine_control_word, // live control word
    output logic [15:0]      legacy_status_word,   // low half of control word
    output logic [31:0]      store_image,      // pushed or saved flags image
    output logic [31:0]      alu_result,       // arithmetic result
    output logic             paging_enable_bit,    // paging unit on
    output logic             protected_mode,   // protected mode on
    output logic             legacy_virtual_mode,  // virtual task running
    output logic             io_direct_ok,     // I/O needs no bitmap check
    output logic             maskable_interrupt_input_recognised,  // interrupt taken this cycle
    output logic             debug_fault_suppress, // mask debug faults
    output logic             return_inter_task,    // return leaves task
    output logic             single_step_trap, // trap pulse after step
    output logic [31:0]      ref_linear,       // linear address of reference
    output logic             ref_limit_fault,  // offset beyond limit
    output logic             ref_attr_fault,   // access not allowed
    output logic [31:0]      next_src_index,   // stepped source index
    output logic [31:0]      next_dst_index    // stepped destination index
);
    // ********************
    // helper functions
    // ********************
    // top bit index of an operand size
    function automatic logic [4:0] top_bit(input size_e s);
        case (s)
            SIZE8:   top_bit = 5'd7;
            SIZE16:  top_bit = 5'd15;
            default: top_bit = 5'd31;
        endcase
    endfunction

    // byte count of an operand size
    function automatic logic [31:0] size_bytes(input size_e s);
        case (s)
            SIZE8:   size_bytes = 32'h0000_0001;
            SIZE16:  size_bytes = 32'h0000_0002;
            default: size_bytes = 32'h0000_0004;
        endcase
    endfunction

    // operand mask of a size
    function automatic logic [31:0] size_mask(input size_e s);
        case (s)
            SIZE8:   size_mask = 32'h0000_00ff;
            SIZE16:  size_mask = 32'h0000_ffff;
            default: size_mask = 32'hffff_ffff;
        endcase
    endfunction

    // ********************
    // state
    // ********************
    logic [31:0] flags;
    logic [31:0] ctrl;
    logic [31:0] next_flags;
    logic [31:0] next_ctrl;
    logic        maskable_interrupt_input_meta;
    logic        maskable_interrupt_input_sync;
    seg_desc_s   segs [NUM_SEGS];

    // ********************
    // decode of the current state
    // ********************
    wire logic [1:0] iopv    = flags[IOPV_LO +: 2];
    wire logic       prot    = ctrl[PM_BIT];
    wire logic       cpl0    = (current_privilege_level == 2'd0);
    wire logic       io_priv = (current_privilege_level <= iopv);
    wire logic       is_pop  = (cmd.op == CMD_POPF16) || (cmd.op == CMD_POPF32)
                               || (cmd.op == CMD_INTERRUPT_RETURN);
    wire logic       is_task = (cmd.op == CMD_TASK_SWITCH);
    wire logic       done_ok = (cmd.op != CMD_NONE) && (cmd.op != CMD_INT_ENTRY)
                               && !cmd.fault;

    // status and control outputs
    assign processor_flags_word = flags;
    assign machine_control_word = ctrl;
    assign legacy_status_word   = ctrl[15:0];
    assign paging_enable_bit    = ctrl[PU_BIT];
    assign protected_mode       = prot;
    assign legacy_virtual_mode  = prot & flags[VT_BIT];
    assign io_direct_ok         = !prot || io_priv;
    assign maskable_interrupt_input_recognised      = maskable_interrupt_input_sync & flags[IF_BIT];
    assign debug_fault_suppress = flags[RS_BIT];
    assign return_inter_task    = flags[NS_BIT];

    // ********************
    // arithmetic flags
    // ********************
    wire logic [4:0]  tb     = top_bit(alu_req.size);
    wire logic [31:0] msk    = size_mask(alu_req.size);
    wire logic [32:0] am     = {1'b0, alu_req.a & msk};
    wire logic [32:0] bm     = {1'b0, alu_req.b & msk};
    wire logic [32:0] raw    = alu_req.sub ? (am - bm) : (am + bm);
    wire logic [31:0] res    = raw[31:0] & msk;
    wire logic        a_s    = am[tb];
    wire logic        b_s    = bm[tb] ^ alu_req.sub;
    wire logic        r_s    = res[tb];
    wire logic        c_top  = raw[{1'b0, tb} + 6'd1];
    wire logic        ovf    = (a_s == b_s) && (r_s != a_s);
    wire logic        aux    = am[4] ^ bm[4] ^ raw[4];
    wire logic        par    = ~^res[7:0];
    wire logic        zero   = (res == 32'h0000_0000);

    // computed arithmetic flags placed at their positions
    wire logic [31:0] alu_flags = (32'(c_top) << CY_BIT) | (32'(par) << PY_BIT)
                                  | (32'(aux) << AC_BIT) | (32'(zero) << ZR_BIT)
                                  | (32'(r_s) << SG_BIT)
                                  | (32'(ovf) << OV_BIT);
    // only flags the instruction defines are replaced
    wire logic [31:0] alu_upd = alu_req.valid ?
                                ((32'(alu_req.update[0]) << CY_BIT)
                                 | (32'(alu_req.update[1]) << PY_BIT)
                                 | (32'(alu_req.update[2]) << AC_BIT)
                                 | (32'(alu_req.update[3]) << ZR_BIT)
                                 | (32'(alu_req.update[4]) << SG_BIT)
                                 | (32'(alu_req.update[5]) << OV_BIT))
                                : 32'h0000_0000;

    // ********************
    // pop and task switch masks
    // ********************
    wire logic [31:0] pop_base = FLAGS_DEFINED & ~FLAGS_IOPV
                                 & ~(32'h1 << IF_BIT) & ~(32'h1 << VT_BIT);
    wire logic [31:0] pop_iopv = cpl0 ? FLAGS_IOPV : 32'h0000_0000;
    wire logic [31:0] pop_if   = io_priv ? (32'h1 << IF_BIT) : 32'h0;
    wire logic [31:0] pop_virt = ((cmd.op == CMD_INTERRUPT_RETURN) && prot && cpl0)
                                 ? (32'h1 << VT_BIT) : 32'h0;
    wire logic [31:0] pop_size = (cmd.op == CMD_POPF16) ? FLAGS_LOW16 : 32'hffff_ffff;
    wire logic [31:0] pop_mask = (pop_base | pop_iopv | pop_if | pop_virt) & pop_size;
    wire logic [31:0] task_mask = FLAGS_DEFINED & ~(prot ? 32'h0 : (32'h1 << VT_BIT));

    // next flags word
    always_comb begin
        next_flags = (flags & ~alu_upd) | (alu_flags & alu_upd);
        if (done_ok && !is_pop && !is_task) begin
            next_flags[RS_BIT] = 1'b0;
        end
        if (is_pop && !cmd.fault) begin
            // nested flag, and resume flag except on a 16-bit pop, come from the image here
            next_flags = (next_flags & ~pop_mask) | (cmd.image & pop_mask);
        end
        if (is_task && !cmd.fault) begin
            // defined bits of incoming image incl. I/O field, virtual bit only in protected mode, nesting set by transfer
            next_flags = cmd.image & task_mask;
            next_flags[NS_BIT] = cmd.nest;
        end
    end

    // ********************
    // machine control word
    // ********************
    wire logic [31:0] sts_val  = {ctrl[31:16], cmd.image[15:1],
                                  cmd.image[PM_BIT] | ctrl[PM_BIT]};

    // next control word
    always_comb begin
        next_ctrl = ctrl;
        if (!cmd.fault && (cmd.op == CMD_LOAD_CONTROL)) begin
            next_ctrl = cmd.image;
        end
        if (!cmd.fault && (cmd.op == CMD_LOAD_STATUS)) begin
            next_ctrl = sts_val;
        end
    end

    // flags and control registers
    always_ff @(posedge clk) begin
        if (reset) begin
            flags <= FLAGS_RESET;
            ctrl  <= CTRL_RESET;
        end else begin
            flags <= next_flags;
            ctrl  <= next_ctrl;
        end
    end

    // ********************
    // stored images, traps and results
    // ********************
    wire logic        cap_push = (cmd.op == CMD_PUSH) && !cmd.fault;
    wire logic        cap_save = (cmd.op == CMD_INT_ENTRY) || (is_task && !cmd.fault);
    wire logic [31:0] push_img = flags & ~(32'h1 << VT_BIT);
    wire logic        step_hit = done_ok && flags[ST_BIT];

    // image capture and step trap
    always_ff @(posedge clk) begin
        if (reset) begin
            store_image      <= 32'h0000_0000;
            single_step_trap <= 1'b0;
            alu_result       <= 32'h0000_0000;
        end else begin
            if (cap_push) begin
                store_image <= push_img;
            end else if (cap_save) begin
                store_image <= flags;
            end
            single_step_trap <= step_hit;
            if (alu_req.valid) begin
                alu_result <= res;
            end
        end
    end

    // ********************
    // interrupt pin synchroniser
    // ********************
    always_ff @(posedge clk) begin
        if (reset) begin
            maskable_interrupt_input_meta <= 1'b0;
            maskable_interrupt_input_sync <= 1'b0;
        end else begin
            maskable_interrupt_input_meta <= maskable_interrupt_input;
            maskable_interrupt_input_sync <= maskable_interrupt_input_meta;
        end
    end

    // ********************
    // string index stepping
    // ********************
    wire logic [31:0] step_amt = size_bytes(str_size);

    // post-increment or post-decrement by element size
    always_ff @(posedge clk) begin
        if (reset) begin
            next_src_index <= 32'h0000_0000;
            next_dst_index <= 32'h0000_0000;
        end else if (str_valid) begin
            if (flags[DR_BIT]) begin
                next_src_index <= str_src - step_amt;
                next_dst_index <= str_dst - step_amt;
            end else begin
                next_src_index <= str_src + step_amt;
                next_dst_index <= str_dst + step_amt;
            end
        end
    end

    // ********************
    // hidden segment descriptors
    // ********************
    wire logic [31:0] real_base = {12'h000, seg_load.selector, 4'h0};
    wire logic        seg_ok    = seg_load.valid && (seg_load.index < 3'(NUM_SEGS));

    // descriptor reload on selector load
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_SEGS; i++) begin
                segs[i] <= '{base: 32'h0, limit: LIMIT_RESET, attr: ATTR_RESET};
            end
        end else if (seg_ok) begin
            if (prot) begin
                segs[seg_load.index] <= seg_load.desc;
            end else begin
                segs[seg_load.index].base <= real_base;
            end
        end
    end

    // ********************
    // memory reference check
    // ********************
    wire logic      ref_ok  = (ref_seg < 3'(NUM_SEGS));
    wire seg_desc_s ref_d   = ref_ok ? segs[ref_seg] : '0;
    wire logic      over    = !ref_ok || (ref_offset > ref_d.limit);
    wire logic      no_perm = !ref_d.attr[ATTR_PRES_BIT]
                              || (ref_write && !ref_d.attr[ATTR_WRITE_BIT]);

    // base add, limit and attribute checks per reference
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_linear      <= 32'h0000_0000;
            ref_limit_fault <= 1'b0;
            ref_attr_fault  <= 1'b0;
        end else if (ref_valid) begin
            ref_linear      <= ref_d.base + ref_offset;
            ref_limit_fault <= over;
            ref_attr_fault  <= prot && no_perm;
        end
    end
endmodule

// >>> sim/flags_state_chk.sv
// checker: port-level properties of the flags and segment state block
module flags_state_chk
    import cpu_state_pkg::*;
(
    input wire logic        clk,                      // clock
    input wire logic        reset,                    // sync reset
    input wire logic        maskable_interrupt_input, // request pin
    input wire logic [1:0]  current_privilege_level,  // privilege
    input wire cmd_s        cmd,                      // command
    input wire logic [31:0] processor_flags_word,     // flags
    input wire logic [31:0] machine_control_word,     // control word
    input wire logic [15:0] legacy_status_word,       // status alias
    input wire logic [31:0] store_image,              // saved image
    input wire logic        paging_enable_bit,        // paging on
    input wire logic        protected_mode,           // protection on
    input wire logic        legacy_virtual_mode,      // virtual task
    input wire logic        io_direct_ok,             // io allowed
    input wire logic        maskable_interrupt_input_recognised,          // interrupt taken
    input wire logic        debug_fault_suppress,     // resume level
    input wire logic        return_inter_task,        // nested level
    input wire logic        single_step_trap          // trap pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // properties
    // ********************
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence stepped_retire;
        cmd.op == CMD_RETIRE && !cmd.fault && processor_flags_word[ST_BIT];
    endsequence
    sequence clean_push;
        cmd.op == CMD_PUSH && !cmd.fault;
    endsequence
    step_trap_a: assert property (stepped_retire |=> single_step_trap)
        else $error("no trap after stepped instruction");
    push_virt_a: assert property (clean_push |=> !store_image[VT_BIT])
        else $error("pushed image carries virtual bit");
    int_virt_a: assert property (cmd.op == CMD_INT_ENTRY && legacy_virtual_mode |=> store_image[VT_BIT])
        else $error("saved image lost virtual bit");
    pop_virt_a: assert property (cmd.op inside {CMD_POPF16, CMD_POPF32} |=> $stable(processor_flags_word[VT_BIT]))
        else $error("pop changed virtual bit");
    retire_rf_a: assert property (cmd.op == CMD_RETIRE && !cmd.fault |=> !debug_fault_suppress)
        else $error("resume flag kept after retire");
    io_gate_a: assert property (io_direct_ok ==
        (!protected_mode || current_privilege_level <= processor_flags_word[13:12]))
        else $error("io permission wrong");
    maskable_interrupt_input_gate_a: assert property (maskable_interrupt_input_recognised ==
        ($past(maskable_interrupt_input, 2) && processor_flags_word[IF_BIT]))
        else $error("interrupt gating wrong");
    prot_hold_a: assert property (cmd.op == CMD_LOAD_STATUS && protected_mode |=> protected_mode)
        else $error("status load cleared protection");
    ctrl_alias_a: assert property (paging_enable_bit == machine_control_word[PU_BIT]
        && legacy_status_word == machine_control_word[15:0])
        else $error("control word views disagree");
    flag_levels_a: assert property (return_inter_task == processor_flags_word[NS_BIT]
        && debug_fault_suppress == processor_flags_word[RS_BIT])
        else $error("flag level outputs wrong");
endmodule

// >>> sim/testbench.sv
// testbench: directed scenarios for the flags and segment state block
module testbench
    import cpu_state_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // signals and design
    // ********************
    logic        clk, reset, maskable_interrupt_input, ref_valid, ref_write, str_valid;
    logic [1:0]  current_privilege_level;
    cmd_s        cmd;
    alu_req_s    alu_req;
    seg_load_s   seg_load;
    logic [2:0]  ref_seg;
    size_e       str_size;
    logic [31:0] ref_offset, str_src, str_dst, processor_flags_word, machine_control_word, store_image;
    logic [31:0] alu_result, ref_linear, next_src_index, next_dst_index;
    logic [15:0] legacy_status_word;
    logic        paging_enable_bit, protected_mode, legacy_virtual_mode, io_direct_ok, maskable_interrupt_input_recognised;
    logic        debug_fault_suppress, return_inter_task, single_step_trap, ref_limit_fault, ref_attr_fault;
    int          error_cnt, cmp_count;
    cpu_flags_and_segment_state DUT (.clk, .reset, .maskable_interrupt_input, .current_privilege_level, .cmd,
        .alu_req, .seg_load, .ref_valid, .ref_seg, .ref_offset, .ref_write, .str_valid, .str_size, .str_src,
        .str_dst, .processor_flags_word, .machine_control_word, .legacy_status_word, .store_image, .alu_result,
        .paging_enable_bit, .protected_mode, .legacy_virtual_mode, .io_direct_ok, .maskable_interrupt_input_recognised,
        .debug_fault_suppress, .return_inter_task, .single_step_trap, .ref_linear, .ref_limit_fault,
        .ref_attr_fault, .next_src_index, .next_dst_index);
    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ********************
    // shared tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one command, outputs settled on return
    task automatic do_cmd(input cmd_e op, input logic [31:0] img, input logic [1:0] pl = 2'd0,
                          input logic nest = 1'b0, input logic flt = 1'b0);
        @(posedge clk);
        cmd <= '{op, flt, nest, img};
        current_privilege_level <= pl;
        @(posedge clk);
        cmd <= '{CMD_NONE, 1'b0, 1'b0, 32'h0};
        #1;
    endtask
    task automatic alu_case(input logic sb, input size_e sz, input logic [5:0] up, input logic [31:0] a, b, res,
                            input logic [5:0] fl);
        @(posedge clk);
        alu_req <= '{1'b1, sb, sz, up, a, b};
        @(posedge clk);
        alu_req.valid <= 1'b0;
        #1;
        chk(alu_result, res);
        chk({26'h0, processor_flags_word[OV_BIT], processor_flags_word[SG_BIT], processor_flags_word[ZR_BIT],
             processor_flags_word[AC_BIT], processor_flags_word[PY_BIT], processor_flags_word[CY_BIT]}, {26'h0, fl});
    endtask
    task automatic mem_ref(input logic [2:0] s, input logic [31:0] off, input logic wr);
        @(posedge clk);
        ref_valid <= 1'b1;
        ref_seg <= s;
        ref_offset <= off;
        ref_write <= wr;
        @(posedge clk);
        ref_valid <= 1'b0;
        #1;
    endtask
    task automatic str_step(input size_e sz);
        @(posedge clk);
        str_valid <= 1'b1;
        str_size <= sz;
        @(posedge clk);
        str_valid <= 1'b0;
        #1;
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_alu;
        alu_case(1'b0, SIZE8, 6'h3f, 32'hff, 32'h1, 32'h0, 6'b001111);
        alu_case(1'b0, SIZE8, 6'h3f, 32'h7f, 32'h1, 32'h80, 6'b110100);
        alu_case(1'b1, SIZE16, 6'h3f, 32'h0, 32'h1, 32'hffff, 6'b010111);
        alu_case(1'b0, SIZE32, 6'h3f, 32'h8000_0000, 32'h8000_0000, 32'h0, 6'b101011);
        alu_case(1'b1, SIZE32, 6'h3f, 32'h8000_0000, 32'h1, 32'h7fff_ffff, 6'b100110);
        alu_case(1'b0, SIZE8, 6'h01, 32'hff, 32'h1, 32'h0, 6'b100111);
    endtask
    task automatic t_pops;
        do_cmd(CMD_POPF32, 32'hffff_ffff);
        chk(processor_flags_word, 32'h0001_7fd5);
        do_cmd(CMD_POPF32, 32'h0, 2'd3);
        chk(processor_flags_word, 32'h0000_3000);
        do_cmd(CMD_POPF32, 32'h0);
        do_cmd(CMD_POPF32, 32'h0000_3200, 2'd1);
        chk(processor_flags_word, 32'h0);
        do_cmd(CMD_POPF16, 32'h0000_ffff);
        chk(processor_flags_word, 32'h0000_7fd5);
        do_cmd(CMD_RETIRE, 32'h0);
        chk({31'h0, single_step_trap}, 32'h1);
        do_cmd(CMD_POPF32, 32'h0001_0000);
        do_cmd(CMD_RETIRE, 32'h0, 2'd0, 1'b0, 1'b1);
        chk({31'h0, debug_fault_suppress}, 32'h1);
        do_cmd(CMD_PUSH, 32'h0);
        chk(store_image, 32'h0001_0000);
        chk(processor_flags_word, 32'h0);
    endtask
    task automatic t_prot;
        do_cmd(CMD_LOAD_STATUS, 32'h1);
        do_cmd(CMD_LOAD_STATUS, 32'h8000_0000);
        chk(machine_control_word, 32'h1);
        do_cmd(CMD_LOAD_CONTROL, 32'h8000_0001);
        chk({31'h0, paging_enable_bit}, 32'h1);
        do_cmd(CMD_INTERRUPT_RETURN, 32'h0002_0000, 2'd3);
        chk({30'h0, processor_flags_word[VT_BIT], io_direct_ok}, 32'h0);
        do_cmd(CMD_INTERRUPT_RETURN, 32'h0002_0000);
        chk({30'h0, legacy_virtual_mode, io_direct_ok}, 32'h3);
        do_cmd(CMD_PUSH, 32'h0);
        chk(store_image, 32'h0);
        do_cmd(CMD_INT_ENTRY, 32'h0);
        chk(store_image, 32'h0002_0000);
        do_cmd(CMD_TASK_SWITCH, 32'h0000_3000, 2'd3, 1'b1);
        chk(processor_flags_word, 32'h0000_7000);
        chk({30'h0, return_inter_task, io_direct_ok}, 32'h3);
        do_cmd(CMD_LOAD_CONTROL, 32'h0);
        chk({30'h0, paging_enable_bit, protected_mode}, 32'h0);
    endtask
    task automatic t_seg;
        @(posedge clk);
        seg_load <= '{1'b1, 3'd3, 16'h1234, '{32'hdead_0000, 32'h0, 8'h00}};
        @(posedge clk);
        seg_load <= '{1'b1, 3'd2, 16'h0008, '{32'h0010_0000, 32'hff, 8'h81}};
        @(posedge clk);
        seg_load.valid <= 1'b0;
        mem_ref(3'd3, 32'h10, 1'b1);
        chk({ref_linear[30:0], ref_limit_fault}, {31'h0001_2350, 1'b0});
        mem_ref(3'd3, 32'h0001_0000, 1'b0);
        chk({31'h0, ref_limit_fault}, 32'h1);
        do_cmd(CMD_LOAD_STATUS, 32'h1);
        @(posedge clk);
        seg_load <= '{1'b1, 3'd2, 16'h0008, '{32'h0010_0000, 32'hff, 8'h81}};
        @(posedge clk);
        seg_load.valid <= 1'b0;
        mem_ref(3'd2, 32'hff, 1'b1);
        chk({ref_linear[29:0], ref_limit_fault, ref_attr_fault}, {30'h0010_00ff, 2'b01});
        mem_ref(3'd2, 32'h100, 1'b0);
        chk({30'h0, ref_limit_fault, ref_attr_fault}, 32'h2);
        do_cmd(CMD_LOAD_CONTROL, 32'h0);
    endtask
    task automatic t_str_maskable_interrupt_input;
        do_cmd(CMD_POPF32, 32'h0);
        @(posedge clk);
        str_src <= 32'h100;
        str_dst <= 32'h200;
        maskable_interrupt_input <= 1'b1;
        str_step(SIZE32);
        chk(next_src_index ^ next_dst_index, 32'h0000_0300);
        chk({31'h0, maskable_interrupt_input_recognised}, 32'h0);
        do_cmd(CMD_POPF32, 32'h0000_0600);
        str_step(SIZE16);
        chk(next_dst_index, 32'h0000_01fe);
        for (int i = 0; i < 5 && maskable_interrupt_input_recognised !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({31'h0, maskable_interrupt_input_recognised}, 32'h1);
        if (maskable_interrupt_input_recognised !== 1'b1) wrap_up();
    endtask
    // main sequence
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        reset = 1'b1;
        {maskable_interrupt_input, ref_valid, ref_write, str_valid} = '0;
        current_privilege_level = 2'd0;
        {cmd, alu_req, seg_load, ref_seg, ref_offset, str_src, str_dst} = '0;
        str_size = SIZE8;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_alu();
        t_pops();
        t_prot();
        t_seg();
        t_str_maskable_interrupt_input();
        wrap_up();
    end
endmodule
bind cpu_flags_and_segment_state flags_state_chk chk_i (.clk, .reset, .maskable_interrupt_input,
    .current_privilege_level, .cmd, .processor_flags_word, .machine_control_word, .legacy_status_word,
    .store_image, .paging_enable_bit, .protected_mode, .legacy_virtual_mode, .io_direct_ok, .maskable_interrupt_input_recognised,
    .debug_fault_suppress, .return_inter_task, .single_step_trap);
